/* pkg/rcd_pkg.sv */
// shared constants and types for the reset clock mode decoder
//
// Functional notes
// - capture three strap pins during hard reset
// - config select adds four high bits, 7-bit code
// - new clock setup only after power-on reset
// - codes 000-011: 33 MHz, comms 3/4, core 4/5
// - codes 100-111: 66 MHz, comms 2/2.5, core 2.5/3
// - codes 0001_000-0001_100: comms 2, core 4..8
// - from 0001_101 comms steps 3..6, core 4..8
// - codes 1000_001-1000_100: comms 3.5, core 3..4.5
// - pci mode select high forces local bus mode
// - host/agent select picks host or agent
// - halving pin high doubles pci division
// - pci mode takes bits from local gp lines
// - host 1010_000: 100 MHz, 2, 2, div 3/6
// - host 1011_000-1011_100: comms 2.5, core 2..4, div 4/8
// - agent 000: comms 2/4, core 2.5, bus div 2
// - agent 010/011: comms 3/6, core 3/4, div 3
package rcd_pkg;

  // synchronised pin vector layout
  localparam int SB_HR = 0;
  localparam int SB_CFG = 1;
  localparam int SB_STRAP = 2;
  localparam int SB_DATAH = 5;
  localparam int SB_VAR = 9;
  localparam int SB_PMODE = 10;
  localparam int SB_HASEL = 11;
  localparam int SB_GP5 = 12;
  localparam int SB_GPLO = 13;
  localparam int SYNC_W = 17;
  // hard reset and config select idle high, pci mode pin idles local
  localparam logic [16:0] SYNC_RST = 17'h0_0403;

  // code boundaries
  localparam logic [6:0] DEF_LAST = 7'h07;
  localparam logic [6:0] EXT2_FIRST = 7'h08;
  localparam logic [6:0] EXT2_LAST = 7'h0C;
  localparam logic [6:0] GRP_FIRST = 7'h0D;
  localparam logic [6:0] GRP_LAST = 7'h20;
  localparam logic [6:0] HI35_FIRST = 7'h41;
  localparam logic [6:0] HI35_LAST = 7'h44;
  localparam logic [6:0] H66_FIRST = 7'h4A;
  localparam logic [6:0] H66_LAST = 7'h4C;
  localparam logic [6:0] H100A_FIRST = 7'h50;
  localparam logic [6:0] H100A_LAST = 7'h54;
  localparam logic [6:0] H100B_FIRST = 7'h58;
  localparam logic [6:0] H100B_LAST = 7'h5C;
  localparam logic [6:0] AGENT_LAST = 7'h03;
  localparam logic [4:0] GRP_SIZE = 5'h05;

  // input frequencies in MHz
  localparam logic [6:0] FREQ_33 = 7'h21;
  localparam logic [6:0] FREQ_66 = 7'h42;
  localparam logic [6:0] FREQ_100 = 7'h64;

  // multipliers in half steps
  localparam logic [4:0] M2 = 5'h04;
  localparam logic [4:0] M2P5 = 5'h05;
  localparam logic [4:0] M3 = 5'h06;
  localparam logic [4:0] M3P5 = 5'h07;
  localparam logic [4:0] M4 = 5'h08;
  localparam logic [4:0] M5 = 5'h0A;

  localparam logic [3:0] PCI_DIV_A = 4'h3;
  localparam logic [3:0] PCI_DIV_B = 4'h4;
  localparam logic [1:0] BUS_DIV_A = 2'h2;
  localparam logic [1:0] BUS_DIV_B = 2'h3;

  localparam logic [6:0] RST_CODE = 7'h00;
  localparam logic [4:0] RST_MULT = 5'h00;

  typedef enum logic [1:0] {CM_LOCAL, CM_PCI_HOST, CM_PCI_AGENT} rcd_cmode_e;
  typedef enum logic [1:0] {PH_ARMED, PH_SAMPLE, PH_LOCKED} rcd_phase_e;

  typedef struct packed {
    rcd_phase_e phase;
    logic [6:0] code;
    rcd_cmode_e cmode;
    logic halved;
    logic locked;
    logic invalid;
    logic [6:0] out_code;
    logic [6:0] freq;
    logic [4:0] comms_processor;
    logic [4:0] core;
    rcd_cmode_e out_mode;
    logic [3:0] pci_div;
    logic [1:0] bus_div;
    logic out_halved;
  } rcd_state_s;

  // doubles a whole-number step into half-step units
  function automatic logic [4:0] mul_x2(input logic [4:0] whole);
    return {whole[3:0], 1'b0};
  endfunction

endpackage

/* core/rcd_sync.sv */
// two-flop synchroniser for the strap and reset pins
`timescale 1ns/1ns
module rcd_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic sys_clk, // system clock
  input wire logic reset_n, // async reset, active low
  input wire logic [W-1:0] din, // raw pins
  output logic [W-1:0] dout // synchronised pins
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } rcd_sync_s;

  rcd_sync_s st;
  rcd_sync_s next_st;

  // meta stage is read by the stable stage only
  always_comb
  begin
    next_st.meta = din;
    next_st.stable = st.meta;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st <= {RST_VAL, RST_VAL};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign dout = st.stable;
endmodule

/* core/rcd_decode.sv */
// mode code to clock ratio lookup
`timescale 1ns/1ns
module rcd_decode (
  input wire logic [6:0] code, // latched 7-bit mode code
  input wire rcd_pkg::rcd_cmode_e cmode, // clocking mode
  input wire logic halved, // pci clock halving
  output logic invalid, // code has no defined ratios
  output logic [6:0] freq, // assumed input MHz
  output logic [4:0] comms_processor, // comms multiplier, half steps
  output logic [4:0] core, // core multiplier, half steps
  output logic [3:0] pci_div, // pci division factor
  output logic [1:0] bus_div // system bus division factor
);
  logic [4:0] off;
  logic [4:0] grp;

  always_comb
  begin
    invalid = 1'b1;
    freq = 7'h00;
    comms_processor = rcd_pkg::RST_MULT;
    core = rcd_pkg::RST_MULT;
    pci_div = 4'h0;
    bus_div = 2'h0;
    off = 5'h00;
    grp = 5'h00;
    unique case (cmode)
      rcd_pkg::CM_LOCAL:
      begin
        if (code <= rcd_pkg::DEF_LAST)
        begin
          invalid = 1'b0;
          if (!code[2])
          begin
            freq = rcd_pkg::FREQ_33;
            comms_processor = code[1] ? rcd_pkg::M4 : rcd_pkg::M3;
            core = code[0] ? rcd_pkg::M5 : rcd_pkg::M4;
          end
          else
          begin
            freq = rcd_pkg::FREQ_66;
            comms_processor = code[1] ? rcd_pkg::M2P5 : rcd_pkg::M2;
            core = code[0] ? rcd_pkg::M3 : rcd_pkg::M2P5;
          end
        end
        else if (code <= rcd_pkg::EXT2_LAST)
        begin
          invalid = 1'b0;
          off = 5'(code - rcd_pkg::EXT2_FIRST);
          freq = rcd_pkg::FREQ_33;
          comms_processor = rcd_pkg::M2;
          core = 5'(rcd_pkg::M4 + rcd_pkg::mul_x2(off));
        end
        else if (code <= rcd_pkg::GRP_LAST)
        begin
          invalid = 1'b0;
          off = 5'(code - rcd_pkg::GRP_FIRST);
          grp = off / rcd_pkg::GRP_SIZE;
          freq = rcd_pkg::FREQ_33;
          comms_processor = 5'(rcd_pkg::M3 + rcd_pkg::mul_x2(grp));
          core = 5'(rcd_pkg::M4 + rcd_pkg::mul_x2(off % rcd_pkg::GRP_SIZE));
        end
        else if (code >= rcd_pkg::HI35_FIRST && code <= rcd_pkg::HI35_LAST)
        begin
          invalid = 1'b0;
          off = 5'(code - rcd_pkg::HI35_FIRST);
          freq = rcd_pkg::FREQ_66;
          comms_processor = rcd_pkg::M3P5;
          core = 5'(rcd_pkg::M3 + off);
        end
      end
      rcd_pkg::CM_PCI_HOST:
      begin
        if (code >= rcd_pkg::H66_FIRST && code <= rcd_pkg::H66_LAST)
        begin
          invalid = 1'b0;
          off = 5'(code - rcd_pkg::H66_FIRST);
          freq = rcd_pkg::FREQ_66;
          comms_processor = rcd_pkg::M3P5;
          core = 5'(rcd_pkg::M3P5 + off);
          pci_div = rcd_pkg::PCI_DIV_B;
        end
        else if (code >= rcd_pkg::H100A_FIRST && code <= rcd_pkg::H100A_LAST)
        begin
          invalid = 1'b0;
          off = 5'(code - rcd_pkg::H100A_FIRST);
          freq = rcd_pkg::FREQ_100;
          comms_processor = rcd_pkg::M2;
          core = 5'(rcd_pkg::M2 + off);
          pci_div = rcd_pkg::PCI_DIV_A;
        end
        else if (code >= rcd_pkg::H100B_FIRST && code <= rcd_pkg::H100B_LAST)
        begin
          invalid = 1'b0;
          off = 5'(code - rcd_pkg::H100B_FIRST);
          freq = rcd_pkg::FREQ_100;
          comms_processor = rcd_pkg::M2P5;
          core = 5'(rcd_pkg::M2 + off);
          pci_div = rcd_pkg::PCI_DIV_B;
        end
        // halving doubles the division, halving the pci clock
        if (halved)
        begin
          pci_div = {pci_div[2:0], 1'b0};
        end
      end
      rcd_pkg::CM_PCI_AGENT:
      begin
        if (code <= rcd_pkg::AGENT_LAST)
        begin
          invalid = 1'b0;
          freq = halved ? rcd_pkg::FREQ_33 : rcd_pkg::FREQ_66;
          comms_processor = code[1] ? rcd_pkg::M3 : rcd_pkg::M2;
          if (halved)
          begin
            comms_processor = {comms_processor[3:0], 1'b0};
          end
          unique case (code[1:0])
            2'b00: core = rcd_pkg::M2P5;
            2'b01: core = rcd_pkg::M3;
            2'b10: core = rcd_pkg::M3;
            2'b11: core = rcd_pkg::M4;
          endcase
          bus_div = code[1] ? rcd_pkg::BUS_DIV_B : rcd_pkg::BUS_DIV_A;
        end
      end
      default:
      begin
        invalid = 1'b1;
      end
    endcase
  end
endmodule

/* core/rcd_top.sv */
// reset-time clock mode capture and decode
`timescale 1ns/1ns
module rcd_top (
  input wire logic sys_clk, // 10 MHz system clock
  input wire logic reset_n, // power-on reset, active low
  input wire logic hard_reset_in_n, // hard reset pin, active low
  input wire logic reset_config_select_n, // config word used, low
  input wire logic [2:0] clock_mode_strap_low, // low mode straps
  input wire logic [3:0] clock_mode_cfg_high, // high bits, data bus
  input wire logic pci_variant, // part has pci interface
  input wire logic pci_mode_local, // high: local bus mode
  input wire logic host_agent_sel, // low host, high agent
  input wire logic local_gp_line5, // pci clock halving source
  input wire logic [3:0] local_gp_line0_3, // high bits in pci mode
  output logic cfg_locked, // configuration latched
  output logic cfg_invalid, // latched code is reserved
  output logic [6:0] mode_code, // latched 7-bit code
  output logic [6:0] in_freq_mhz, // assumed input frequency
  output logic [4:0] cpm_mult_x2, // comms multiplier, halves
  output logic [4:0] core_mult_x2, // core multiplier, halves
  output logic [1:0] clk_mode, // local, pci host, pci agent
  output logic [3:0] pci_div, // pci division factor
  output logic [1:0] bus_div, // bus division, agent mode
  output logic pci_clock_halving // halving latched
);

  // ----------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------
  logic [rcd_pkg::SYNC_W-1:0] raw;
  logic [rcd_pkg::SYNC_W-1:0] sy;

  assign raw = {local_gp_line0_3, local_gp_line5, host_agent_sel,
                pci_mode_local, pci_variant, clock_mode_cfg_high,
                clock_mode_strap_low, reset_config_select_n,
                hard_reset_in_n};

  rcd_sync #(
    .W(rcd_pkg::SYNC_W),
    .RST_VAL(rcd_pkg::SYNC_RST)
  ) u_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .din(raw),
    .dout(sy)
  );

  logic hr_act;
  logic cfg_sel;
  logic is_pci;
  logic [2:0] s_strap;
  logic [3:0] s_datah;
  logic [3:0] s_gplo;
  logic [3:0] high;
  rcd_pkg::rcd_cmode_e cap_mode;

  assign hr_act = !sy[rcd_pkg::SB_HR];
  assign cfg_sel = !sy[rcd_pkg::SB_CFG];
  assign s_strap = sy[rcd_pkg::SB_STRAP +: 3];
  assign s_datah = sy[rcd_pkg::SB_DATAH +: 4];
  assign s_gplo = sy[rcd_pkg::SB_GPLO +: 4];
  // pci clocking only on pci parts with the mode pin low
  assign is_pci = sy[rcd_pkg::SB_VAR] && !sy[rcd_pkg::SB_PMODE];

  always_comb
  begin
    if (!is_pci)
    begin
      cap_mode = rcd_pkg::CM_LOCAL;
    end
    else if (sy[rcd_pkg::SB_HASEL])
    begin
      cap_mode = rcd_pkg::CM_PCI_AGENT;
    end
    else
    begin
      cap_mode = rcd_pkg::CM_PCI_HOST;
    end
  end

  // high bits are zero without config select, else the gp lines in pci mode, else the data bus
  assign high = !cfg_sel ? 4'h0 : (is_pci ? s_gplo : s_datah);

  // ----------------------------------------------------------
  // decode of the captured code
  // ----------------------------------------------------------
  rcd_pkg::rcd_state_s st;
  rcd_pkg::rcd_state_s next_st;

  logic d_invalid;
  logic [6:0] d_freq;
  logic [4:0] d_cpm;
  logic [4:0] d_core;
  logic [3:0] d_pci_div;
  logic [1:0] d_bus_div;

  rcd_decode u_decode (
    .code(st.code),
    .cmode(st.cmode),
    .halved(st.halved),
    .invalid(d_invalid),
    .freq(d_freq),
    .comms_processor(d_cpm),
    .core(d_core),
    .pci_div(d_pci_div),
    .bus_div(d_bus_div)
  );

  // ----------------------------------------------------------
  // capture sequence
  // ----------------------------------------------------------
  always_comb
  begin
    next_st = st;
    unique case (st.phase)
      rcd_pkg::PH_ARMED,
      rcd_pkg::PH_SAMPLE:
      begin
        if (hr_act)
        begin
          // keep tracking the pins while hard reset is held
          next_st.phase = rcd_pkg::PH_SAMPLE;
          next_st.code = {high, s_strap};
          next_st.cmode = cap_mode;
          next_st.halved = is_pci && sy[rcd_pkg::SB_GP5];
        end
        else if (st.phase == rcd_pkg::PH_SAMPLE)
        begin
          next_st.phase = rcd_pkg::PH_LOCKED;
          next_st.locked = 1'b1;
          next_st.invalid = d_invalid;
          next_st.out_code = st.code;
          next_st.freq = d_freq;
          next_st.comms_processor = d_cpm;
          next_st.core = d_core;
          next_st.out_mode = st.cmode;
          next_st.pci_div = d_pci_div;
          next_st.bus_div = d_bus_div;
          next_st.out_halved = st.halved;
        end
      end
      rcd_pkg::PH_LOCKED:
      begin
        // later hard resets leave the setup alone; only power-on
        // reset rearms capture
        next_st.phase = rcd_pkg::PH_LOCKED;
      end
      default:
      begin
        next_st.phase = rcd_pkg::PH_ARMED;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st <= '{phase: rcd_pkg::PH_ARMED, code: rcd_pkg::RST_CODE,
              cmode: rcd_pkg::CM_LOCAL, halved: 1'b0, locked: 1'b0,
              invalid: 1'b0, out_code: rcd_pkg::RST_CODE,
              freq: 7'h00, comms_processor: rcd_pkg::RST_MULT,
              core: rcd_pkg::RST_MULT, out_mode: rcd_pkg::CM_LOCAL,
              pci_div: 4'h0, bus_div: 2'h0, out_halved: 1'b0};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign cfg_locked = st.locked;
  assign cfg_invalid = st.invalid;
  assign mode_code = st.out_code;
  assign in_freq_mhz = st.freq;
  assign cpm_mult_x2 = st.comms_processor;
  assign core_mult_x2 = st.core;
  assign clk_mode = st.out_mode;
  assign pci_div = st.pci_div;
  assign bus_div = st.bus_div;
  assign pci_clock_halving = st.out_halved;

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  logic loc_ok;
  assign loc_ok = cfg_locked && clk_mode == rcd_pkg::CM_LOCAL;

  sequence s_held;
    st.phase == rcd_pkg::PH_SAMPLE && hr_act;
  endsequence

  sequence s_release;
    st.phase == rcd_pkg::PH_SAMPLE && !hr_act;
  endsequence

  chk_strap_capture: assert property (
    s_held |=> st.code[2:0] == $past(s_strap) && !cfg_locked)
    else $error("strap bits not captured during hard reset");

  chk_gp_high_bits: assert property (
    (s_held and (cfg_sel && is_pci)) |=> st.code[6:3] == $past(s_gplo))
    else $error("high bits not taken from gp lines");

  chk_lock_release: assert property (
    s_release |=> cfg_locked && mode_code == $past(st.code) ##1 cfg_locked)
    else $error("code not latched on hard reset release");

  chk_no_reconfig: assert property (
    (cfg_locked ##1 hr_act) |=> $stable(mode_code) && $stable(core_mult_x2)
      ##1 $stable(cpm_mult_x2))
    else $error("hard reset changed locked setup");

  chk_hold_stable: assert property (
    cfg_locked |=> cfg_locked && $stable(in_freq_mhz) && $stable(clk_mode))
    else $error("latched setup drifted");

  chk_default_33: assert property (
    (loc_ok && mode_code <= 7'h03) |-> in_freq_mhz == 7'h21
      && cpm_mult_x2 == (mode_code[1] ? 5'h08 : 5'h06)
      && core_mult_x2 == (mode_code[0] ? 5'h0A : 5'h08))
    else $error("default 33 MHz ratios wrong");

  chk_default_66: assert property (
    (loc_ok && mode_code >= 7'h04 && mode_code <= 7'h07)
      |-> in_freq_mhz == 7'h42
      && cpm_mult_x2 == (mode_code[1] ? 5'h05 : 5'h04)
      && core_mult_x2 == (mode_code[0] ? 5'h06 : 5'h05))
    else $error("default 66 MHz ratios wrong");

  chk_ext_cpm2: assert property (
    (loc_ok && mode_code == 7'h0C) |-> cpm_mult_x2 == 5'h04
      && core_mult_x2 == 5'h10)
    else $error("extended comms-2 group wrong");

  chk_group_step: assert property (
    (loc_ok && mode_code == 7'h11) |-> cpm_mult_x2 == 5'h06
      && core_mult_x2 == 5'h10 && !cfg_invalid)
    else $error("stepped group ratio wrong");

  chk_hi_cpm35: assert property (
    (loc_ok && mode_code == 7'h44) |-> cpm_mult_x2 == 5'h07
      && core_mult_x2 == 5'h09 && in_freq_mhz == 7'h42)
    else $error("comms 3.5 group wrong");

  chk_reserved: assert property (
    (loc_ok && mode_code > 7'h20 && mode_code < 7'h41)
      |-> cfg_invalid && cpm_mult_x2 == 5'h00)
    else $error("reserved code decoded as valid");

  chk_local_force: assert property (
    (s_held and sy[rcd_pkg::SB_PMODE])
      |=> st.cmode == rcd_pkg::CM_LOCAL)
    else $error("pci mode pin high did not force local");

  chk_host_div: assert property (
    (cfg_locked && clk_mode == rcd_pkg::CM_PCI_HOST
      && mode_code == 7'h50) |-> in_freq_mhz == 7'h64
      && pci_div == (pci_clock_halving ? 4'h6 : 4'h3))
    else $error("host 100 MHz division wrong");

  chk_host_b_div: assert property (
    (cfg_locked && clk_mode == rcd_pkg::CM_PCI_HOST
      && mode_code == 7'h5C) |-> cpm_mult_x2 == 5'h05
      && core_mult_x2 == 5'h08
      && pci_div == (pci_clock_halving ? 4'h8 : 4'h4))
    else $error("host 2.5 group division wrong");

  chk_agent_ratio: assert property (
    (cfg_locked && clk_mode == rcd_pkg::CM_PCI_AGENT
      && mode_code == 7'h00) |-> core_mult_x2 == 5'h05
      && bus_div == 2'h2
      && cpm_mult_x2 == (pci_clock_halving ? 5'h08 : 5'h04))
    else $error("agent code 000 ratios wrong");

  chk_agent_div3: assert property (
    (cfg_locked && clk_mode == rcd_pkg::CM_PCI_AGENT
      && mode_code == 7'h03) |-> core_mult_x2 == 5'h08
      && bus_div == 2'h3
      && cpm_mult_x2 == (pci_clock_halving ? 5'h0C : 5'h06))
    else $error("agent code 011 ratios wrong");

endmodule

/* tb/rcd_board.sv */
// board strapping and reset configuration source model
`timescale 1ns/1ns
module rcd_board (
  input wire logic sys_clk, // system clock
  output logic hard_reset_in_n, // hard reset pin, active low
  output logic reset_config_select_n, // config word used, low
  output logic [2:0] clock_mode_strap_low, // low mode straps
  output logic [3:0] clock_mode_cfg_high, // data bus high bits
  output logic pci_variant, // part has pci interface
  output logic pci_mode_local, // high: local bus mode
  output logic host_agent_sel, // low host, high agent
  output logic local_gp_line5, // halving source
  output logic [3:0] local_gp_line0_3 // high bits in pci mode
);
  initial
  begin
    hard_reset_in_n = 1'h1;
    reset_config_select_n = 1'h1;
    clock_mode_strap_low = 3'h0;
    clock_mode_cfg_high = 4'h0;
    pci_variant = 1'h0;
    pci_mode_local = 1'h1;
    host_agent_sel = 1'h0;
    local_gp_line5 = 1'h0;
    local_gp_line0_3 = 4'h0;
  end

  // -------------------------------------------------------
  // one hard reset sequence with the given straps
  // -------------------------------------------------------
  // pins = {variant, local, host_agent, halving}
  task automatic strap_reset(input logic [3:0] pins, input logic [6:0] code);
    logic use_gp;
    use_gp = pins[3] & ~pins[2];
    @(posedge sys_clk);
    #5;
    {pci_variant, pci_mode_local, host_agent_sel, local_gp_line5} = pins;
    reset_config_select_n = (code[6:3] == 4'h0);
    clock_mode_strap_low = code[2:0];
    // the unused source carries the inverse so a wrong pick shows
    clock_mode_cfg_high = use_gp ? ~code[6:3] : code[6:3];
    local_gp_line0_3 = use_gp ? code[6:3] : ~code[6:3];
    hard_reset_in_n = 1'h0;
    repeat (3) @(posedge sys_clk);
    #5;
    hard_reset_in_n = 1'h1;
    repeat (3) @(posedge sys_clk);
    #5;
    // shared lines go back to normal traffic after reset
    clock_mode_cfg_high = ~clock_mode_cfg_high;
    local_gp_line0_3 = ~local_gp_line0_3;
    local_gp_line5 = ~local_gp_line5;
    reset_config_select_n = 1'h1;
  endtask
endmodule

/* tb/tb_top.sv */
// self-checking testbench for the clock mode decoder
`timescale 1ns/1ns
module tb_top;
  logic sys_clk, reset_n;
  logic hr_n, cs_n, pv, pl, ha, g5;
  logic [2:0] strap;
  logic [3:0] hi, gp;
  logic cfg_locked, cfg_invalid, pci_clock_halving;
  logic [6:0] mode_code, in_freq_mhz;
  logic [4:0] cpm_mult_x2, core_mult_x2;
  logic [1:0] clk_mode, bus_div;
  logic [3:0] pci_div;
  int n_errors = 0;
  int checked = 0;

  rcd_board board (.sys_clk(sys_clk), .hard_reset_in_n(hr_n),
    .reset_config_select_n(cs_n), .clock_mode_strap_low(strap),
    .clock_mode_cfg_high(hi), .pci_variant(pv), .pci_mode_local(pl),
    .host_agent_sel(ha), .local_gp_line5(g5), .local_gp_line0_3(gp));

  rcd_top dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .hard_reset_in_n(hr_n), .reset_config_select_n(cs_n),
    .clock_mode_strap_low(strap), .clock_mode_cfg_high(hi),
    .pci_variant(pv), .pci_mode_local(pl), .host_agent_sel(ha),
    .local_gp_line5(g5), .local_gp_line0_3(gp),
    .cfg_locked(cfg_locked), .cfg_invalid(cfg_invalid),
    .mode_code(mode_code), .in_freq_mhz(in_freq_mhz),
    .cpm_mult_x2(cpm_mult_x2), .core_mult_x2(core_mult_x2),
    .clk_mode(clk_mode), .pci_div(pci_div), .bus_div(bus_div),
    .pci_clock_halving(pci_clock_halving));

  initial
  begin
    sys_clk = 1'h0;
    forever #50 sys_clk = ~sys_clk;
  end

  // -------------------------------------------------------
  // helpers
  // -------------------------------------------------------
  task automatic chk(input string name, input logic [6:0] exp,
                     input logic [6:0] got);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // power-on reset, the only thing that rearms capture
  task automatic por;
    @(posedge sys_clk);
    #5;
    reset_n = 1'h0;
    @(posedge sys_clk);
    #5;
    chk("locked_in_reset", 7'h00, {6'h00, cfg_locked});
    chk("code_in_reset", 7'h00, mode_code);
    reset_n = 1'h1;
  endtask

  task automatic wait_lock;
    for (int i = 0; i < 20 && cfg_locked !== 1'h1; i++)
      @(posedge sys_clk);
    #5;
    chk("locked", 7'h01, {6'h00, cfg_locked});
  endtask

  // expected ratios of zero mark a reserved code
  task automatic run(input logic [3:0] pins, input logic [6:0] code,
    input logic [6:0] f, input logic [4:0] cm, input logic [4:0] co,
    input logic [1:0] md, input logic [3:0] pd, input logic [1:0] bd);
    por();
    board.strap_reset(pins, code);
    wait_lock();
    // lines have already changed; settings must not follow them
    repeat (5) @(posedge sys_clk);
    #5;
    chk("code", code, mode_code);
    chk("invalid", {6'h00, cm == 5'h00}, {6'h00, cfg_invalid});
    chk("freq", f, in_freq_mhz);
    chk("cpm", {2'h0, cm}, {2'h0, cpm_mult_x2});
    chk("core", {2'h0, co}, {2'h0, core_mult_x2});
    chk("mode", {5'h00, md}, {5'h00, clk_mode});
    chk("pci_div", {3'h0, pd}, {3'h0, pci_div});
    chk("bus_div", {5'h00, bd}, {5'h00, bus_div});
    chk("halving", {6'h00, pins[3] & ~pins[2] & pins[0]},
        {6'h00, pci_clock_halving});
  endtask

  initial
  begin
    #200_000;
    n_errors++;
    close_out();
  end

  // -------------------------------------------------------
  // main sequence
  // -------------------------------------------------------
  initial
  begin
    reset_n = 1'h0;
    repeat (3) @(posedge sys_clk);
    #5;
    reset_n = 1'h1;
    run(4'h4, 7'h00, 7'h21, 5'h06, 5'h08, 2'h0, 4'h0, 2'h0);
    run(4'h4, 7'h03, 7'h21, 5'h08, 5'h0A, 2'h0, 4'h0, 2'h0);
    run(4'h4, 7'h05, 7'h42, 5'h04, 5'h06, 2'h0, 4'h0, 2'h0);
    run(4'h4, 7'h06, 7'h42, 5'h05, 5'h05, 2'h0, 4'h0, 2'h0);
    // a hard reset alone leaves the settings untouched
    board.strap_reset(4'h4, 7'h44);
    repeat (5) @(posedge sys_clk);
    #5;
    chk("code_kept", 7'h06, mode_code);
    chk("cpm_kept", 7'h05, {2'h0, cpm_mult_x2});
    run(4'h4, 7'h08, 7'h21, 5'h04, 5'h08, 2'h0, 4'h0, 2'h0);
    run(4'h4, 7'h0C, 7'h21, 5'h04, 5'h10, 2'h0, 4'h0, 2'h0);
    run(4'h4, 7'h11, 7'h21, 5'h06, 5'h10, 2'h0, 4'h0, 2'h0);
    run(4'h4, 7'h20, 7'h21, 5'h0C, 5'h10, 2'h0, 4'h0, 2'h0);
    run(4'h4, 7'h41, 7'h42, 5'h07, 5'h06, 2'h0, 4'h0, 2'h0);
    run(4'h4, 7'h44, 7'h42, 5'h07, 5'h09, 2'h0, 4'h0, 2'h0);
    run(4'h4, 7'h21, 7'h00, 5'h00, 5'h00, 2'h0, 4'h0, 2'h0);
    run(4'hD, 7'h08, 7'h21, 5'h04, 5'h08, 2'h0, 4'h0, 2'h0);
    run(4'h8, 7'h50, 7'h64, 5'h04, 5'h04, 2'h1, 4'h3, 2'h0);
    run(4'h9, 7'h50, 7'h64, 5'h04, 5'h04, 2'h1, 4'h6, 2'h0);
    run(4'h9, 7'h5C, 7'h64, 5'h05, 5'h08, 2'h1, 4'h8, 2'h0);
    run(4'h8, 7'h58, 7'h64, 5'h05, 5'h04, 2'h1, 4'h4, 2'h0);
    run(4'h8, 7'h4A, 7'h42, 5'h07, 5'h07, 2'h1, 4'h4, 2'h0);
    run(4'hA, 7'h08, 7'h00, 5'h00, 5'h00, 2'h2, 4'h0, 2'h0);
    run(4'hA, 7'h00, 7'h42, 5'h04, 5'h05, 2'h2, 4'h0, 2'h2);
    run(4'hB, 7'h00, 7'h21, 5'h08, 5'h05, 2'h2, 4'h0, 2'h2);
    run(4'hB, 7'h03, 7'h21, 5'h0C, 5'h08, 2'h2, 4'h0, 2'h3);
    run(4'hA, 7'h02, 7'h42, 5'h06, 5'h06, 2'h2, 4'h0, 2'h3);
    close_out();
  end
endmodule
